// ### core/pks_pkg.sv
package pks_pkg;

  // ==========================================
  // Timing
  localparam int SETTLE_NS        = 1000;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int SETTLE_CYC       = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W         = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);
  localparam int DEB_SCANS        = 3;
  localparam logic [1:0] DEB_LAST = 2'(DEB_SCANS - 1);
  localparam int LCD_HOLD_NS      = 500;
  localparam int LCD_HOLD_CYC     = LCD_HOLD_NS / CLK_PERIOD_NS;
  localparam logic [SETTLE_W-1:0] LCD_LAST = SETTLE_W'(LCD_HOLD_CYC - 1);

  // ==========================================
  // Reset values
  localparam logic [2:0]  COL_RST  = 3'h0;
  localparam logic [31:0] KEYS_RST = 32'h0000_0000;

  // ==========================================
  // Types
  typedef enum logic [1:0] {
    ST_SCAN   = 2'b00,
    ST_SENSOR = 2'b01,
    ST_LCD    = 2'b10
  } pks_state_t;

  typedef struct packed {
    logic [2:0] scan_select;
    logic       display_strobe_line;
    logic       panel_function_select;
  } pks_pins_t;

  typedef struct packed {
    logic doc_present;
    logic read_start;
  } pks_sensors_t;

endpackage

// ### core/pks_panel.sv
`timescale 1ns/1ps
`default_nettype none
module pks_panel (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [3:0]            key_return_lines,
  input  wire logic                  doc_sensor_pin,
  input  wire logic                  read_start_sensor_pin,
  input  wire logic                  lcd_req,
  input  wire logic [3:0]            lcd_nibble,
  input  wire logic                  lcd_strobe_level,
  output logic                       lcd_busy,
  output pks_pkg::pks_pins_t         pins,
  output logic [31:0]                key_state,
  output logic                       key_event,
  output pks_pkg::pks_sensors_t      sensors
);

  // ==========================================
  // Input synchronisers
  logic [3:0] kr_s1_r, kr_s1_nxt;
  logic [3:0] kr_s2_r, kr_s2_nxt;
  logic [1:0] sn_s1_r, sn_s1_nxt;
  logic [1:0] sn_s2_r, sn_s2_nxt;

  always_comb begin
    kr_s1_nxt = key_return_lines;
    kr_s2_nxt = kr_s1_r;
    sn_s1_nxt = {doc_sensor_pin, read_start_sensor_pin};
    sn_s2_nxt = sn_s1_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kr_s1_r <= '0;
      kr_s2_r <= '0;
      sn_s1_r <= '0;
      sn_s2_r <= '0;
    end else begin
      kr_s1_r <= kr_s1_nxt;
      kr_s2_r <= kr_s2_nxt;
      sn_s1_r <= sn_s1_nxt;
      sn_s2_r <= sn_s2_nxt;
    end
  end

  // ==========================================
  // Phase sequencer
  pks_pkg::pks_state_t            st_r, st_nxt;
  logic [2:0]                     col_r, col_nxt;
  logic [pks_pkg::SETTLE_W-1:0]   cnt_r, cnt_nxt;
  logic                           col_done;
  logic                           scan_done;
  logic                           sense_done;

  always_comb begin
    st_nxt     = st_r;
    col_nxt    = col_r;
    cnt_nxt    = cnt_r;
    col_done   = 1'b0;
    scan_done  = 1'b0;
    sense_done = 1'b0;
    unique case (st_r)
      pks_pkg::ST_SCAN: begin
        if (cnt_r != pks_pkg::SETTLE_LAST) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt  = '0;
          col_done = 1'b1;
          col_nxt  = col_r + 1'b1;
          if (col_r == 3'h7) begin
            scan_done = 1'b1;
            st_nxt    = pks_pkg::ST_SENSOR;
          end
        end
      end
      pks_pkg::ST_SENSOR: begin
        if (cnt_r != pks_pkg::SETTLE_LAST) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt    = '0;
          sense_done = 1'b1;
          if (lcd_req) begin
            st_nxt = pks_pkg::ST_LCD;
          end else begin
            st_nxt = pks_pkg::ST_SCAN;
          end
        end
      end
      pks_pkg::ST_LCD: begin
        if (cnt_r != pks_pkg::LCD_LAST) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt = '0;
          st_nxt  = pks_pkg::ST_SCAN;
        end
      end
      default: st_nxt = pks_pkg::ST_SCAN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r  <= pks_pkg::ST_SCAN;
      col_r <= pks_pkg::COL_RST;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      col_r <= col_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================
  // Key capture and debounce
  logic [31:0]                    raw_r, raw_nxt;
  logic [31:0]                    keys_r, keys_nxt;
  logic [1:0]                     deb_r, deb_nxt;
  logic                           evt_r, evt_nxt;

  always_comb begin
    raw_nxt  = raw_r;
    keys_nxt = keys_r;
    deb_nxt  = deb_r;
    evt_nxt  = 1'b0;
    if (col_done) begin
      raw_nxt[{col_r, 2'b00} +: 4] = kr_s2_r;
    end
    if (scan_done) begin
      if (raw_nxt == keys_r) begin
        deb_nxt = '0;
      end else if (deb_r == pks_pkg::DEB_LAST) begin
        keys_nxt = raw_nxt;
        evt_nxt  = 1'b1;
        deb_nxt  = '0;
      end else begin
        deb_nxt = deb_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_r  <= pks_pkg::KEYS_RST;
      keys_r <= pks_pkg::KEYS_RST;
      deb_r  <= '0;
      evt_r  <= 1'b0;
    end else begin
      raw_r  <= raw_nxt;
      keys_r <= keys_nxt;
      deb_r  <= deb_nxt;
      evt_r  <= evt_nxt;
    end
  end

  // ==========================================
  // Sensor capture
  pks_pkg::pks_sensors_t          sen_r, sen_nxt;

  always_comb begin
    sen_nxt = sen_r;
    if (sense_done) begin
      sen_nxt = pks_pkg::pks_sensors_t'(sn_s2_r);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sen_r <= '0;
    end else begin
      sen_r <= sen_nxt;
    end
  end

  // ==========================================
  // Display phase flag
  logic                           busy_r, busy_nxt;

  always_comb begin
    busy_nxt = (st_nxt == pks_pkg::ST_LCD);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ==========================================
  // Shared pin drive
  pks_pkg::pks_pins_t             pins_r, pins_nxt;

  always_comb begin
    pins_nxt = pins_r;
    unique case (st_nxt)
      pks_pkg::ST_SCAN: begin
        pins_nxt.panel_function_select = 1'b1;
        pins_nxt.scan_select           = col_nxt;
        pins_nxt.display_strobe_line   = lcd_strobe_level;
      end
      pks_pkg::ST_SENSOR: begin
        pins_nxt.panel_function_select = 1'b0;
        pins_nxt.display_strobe_line   = lcd_strobe_level;
      end
      pks_pkg::ST_LCD: begin
        pins_nxt.panel_function_select = 1'b0;
        pins_nxt.scan_select           = lcd_nibble[2:0];
        pins_nxt.display_strobe_line   = lcd_nibble[3];
      end
      default: pins_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign pins      = pins_r;
  assign key_state = keys_r;
  assign key_event = evt_r;
  assign sensors   = sen_r;
  assign lcd_busy  = busy_r;

endmodule
`default_nettype wire

// ### test/pks_panel_props.sv
`timescale 1ns/1ps
`default_nettype none
module pks_panel_props (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic [3:0]            lcd_nibble,
  input wire logic                  lcd_busy,
  input wire pks_pkg::pks_pins_t    pins,
  input wire pks_pkg::pks_sensors_t sensors
);
  wire logic       sel = pins.panel_function_select;
  wire logic [2:0] col = pins.scan_select;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_START: assert property ($rose(sel) |-> col == 3'h0) else $error("scan start");
  AST_STEP: assert property ($past(sel) && sel && $changed(col) && col != 3'h0 |-> col == $past(col) + 3'h1)
    else $error("column step");
  AST_SETTLE: assert property (sel && $changed(col) |=> $stable(col)[*8]) else $error("settle");
  AST_LAST: assert property ($fell(sel) |-> $past(col) == 3'h7) else $error("last column");
  AST_SENSE: assert property ($changed(sensors) |-> !$past(sel)) else $error("sensor phase");
  AST_NIB: assert property ($rose(lcd_busy) |-> {pins.display_strobe_line, col} == $past(lcd_nibble))
    else $error("lcd nibble");
  cover property ($rose(lcd_busy));
  cover property ($fell(sel));
  cover property ($changed(sensors));
endmodule
bind pks_panel pks_panel_props pks_panel_props_inst (.*);
`default_nettype wire

// ### test/pks_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module pks_panel_model (
  input wire pks_pkg::pks_pins_t pins,
  input wire logic [31:0]        pressed,
  output logic [3:0]             key_return_lines
);
  assign key_return_lines = pins.panel_function_select ? pressed[pins.scan_select*4 +: 4] : ~pressed[3:0];
endmodule
`default_nettype wire

// ### test/pks_panel_test.sv
`timescale 1ns/1ps
`default_nettype none
module pks_panel_test;
  logic clk = 0, sys_rst = 1, lcd_req = 0, lcd_strobe_level = 0, lcd_busy, key_event;
  logic doc_sensor_pin = 1, read_start_sensor_pin = 0;
  logic [3:0] lcd_nibble = 4'hA, key_return_lines;
  logic [31:0] pressed = 32'h8000_0001, key_state;
  pks_pkg::pks_pins_t pins;
  pks_pkg::pks_sensors_t sensors;
  int n_errors = 0, checks_done = 0;
  pks_panel pks_panel_inst (.*);
  pks_panel_model pks_panel_model_inst (.*);
  initial forever #2 clk = ~clk;
  task chk(input string w, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s %h %h", w, e, g);
    end
  endtask
  task automatic wfor(ref logic s, input logic v);
    for (int i = 0; i < 12000 && s !== v; i++) @(posedge clk) #1;
  endtask
  task t_keys;
    wfor(key_event, 1'b1);
    wfor(key_event, 1'b0);
    chk("keys", 32'h8000_0001, key_state);
  endtask
  task t_sens;
    chk("sensors", 32'h2, 32'(sensors));
  endtask
  task t_lcd;
    @(posedge clk) lcd_req <= 1'b1;
    wfor(lcd_busy, 1'b1);
    chk("nibble", 32'hA, {pins.display_strobe_line, pins.scan_select});
    @(posedge clk) lcd_req <= 1'b0;
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_keys;
    t_sens;
    t_lcd;
    conclude;
  end
  initial begin
    #200000 n_errors++;
    conclude;
  end
endmodule
`default_nettype wire
